/* File: rtl/fcp_pkg.sv */
// Package of register map, field positions and carriers for the feature connector pin control
package fcp_pkg;

   // ***************************************************************
   // Register map, word aligned byte offsets
   // ***************************************************************
   localparam logic [7:0] SEQ_EXT_CTRL_B_OFFSET = 8'h00;
   localparam logic [7:0] SEQ_EXT_CTRL_D_OFFSET = 8'h04;
   localparam logic [7:0] PIN_MODE_OFFSET = 8'h08;
   localparam logic [7:0] OUTPUT_VALUE_OFFSET = 8'h0C;
   localparam logic [7:0] PIN_STATUS_OFFSET = 8'h10;
   localparam logic [7:0] CAPTURE_DATA_OFFSET = 8'h14;

   // ***************************************************************
   // Field positions and reset values
   // ***************************************************************
   localparam int CAPTURE_ENABLE_BIT = 1;
   localparam int FEATURE_ENABLE_BIT = 0;
   localparam int GENERAL_OUTPUT_MODE_BIT = 1;
   localparam logic [1:0] PIN_MODE_FEATURE = 2'h0;
   localparam logic [7:0] SEQ_EXT_CTRL_B_RESET = 8'h00;
   localparam logic [7:0] SEQ_EXT_CTRL_D_RESET = 8'h00;
   localparam logic [7:0] PIN_MODE_RESET = 8'h00;
   localparam logic [7:0] OUTPUT_VALUE_RESET = 8'h00;
   localparam logic [1:0] STRAP_SETTLE_COUNT = 2'h2;
   localparam int PIXEL_WIDTH = 16;

   // ***************************************************************
   // Carriers
   // ***************************************************************
   typedef struct packed {
      logic hsync;
      logic vsync;
      logic blankN;
   } fcp_sync_type;

   typedef struct packed {
      logic externalSync;
      logic externalVideo;
      logic externalPixclk;
   } fcp_select_type;

endpackage : fcp_pkg

/* File: rtl/fcp_sync2.sv */
// Two flip-flop synchroniser for pin inputs
module fcp_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Data
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_reg;

   // First stage is read only by the second stage
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         stage1_reg <= '0;
         syncOut <= '0;
      end else begin
         stage1_reg <= asyncIn;
         syncOut <= stage1_reg;
      end
   end

endmodule : fcp_sync2

/* File: rtl/fcp_pin_control.sv */
// Feature connector pin direction, function and register control
module fcp_pin_control (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Select and strap pins
   input wire logic external_sync_select,
   input wire logic external_video_select,
   input wire logic external_pixclk_select,
   input wire logic clock_bypass_strap,
   input wire logic dac_power_down_n,
   // Internal video source, same clock
   input wire fcp_pkg::fcp_sync_type intSync,
   input wire logic [15:0] intPixel,
   input wire logic intPixelClock,
   // Sync and blank pins
   input wire fcp_pkg::fcp_sync_type syncPinIn,
   output fcp_pkg::fcp_sync_type syncPinOut,
   output fcp_pkg::fcp_sync_type syncPinOe,
   // Pixel line pins
   input wire logic [15:0] pixel_lines_in,
   output logic [15:0] pixel_lines_out,
   output logic [15:0] pixel_lines_oe,
   // Pixel clock pin and capture clock pin
   input wire logic pixel_clock_pin_in,
   output logic pixel_clock_pin_out,
   output logic pixel_clock_pin_oe,
   input wire logic capture_pixel_clock_in,
   // Shared feature enable / general output 0 pin
   input wire logic feature_enable_n_in,
   output logic feature_enable_n_out,
   output logic feature_enable_n_oe,
   // Shared strobe / general output 1 pin
   output logic general_output_pin1,
   // To the video back end
   output fcp_pkg::fcp_sync_type extSync,
   output logic videoOutputOn,
   output logic dacAnalogOn,
   output logic [15:0] capturedPixel,
   output logic capturedValid,
   output logic testPixelClock,
   output logic memClockBypassOn,
   output logic memClockBypass,
   output logic dotClockBypass
);

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   logic [26:0] pinRaw;
   logic [26:0] pinSync;
   fcp_pkg::fcp_select_type selSync;
   fcp_pkg::fcp_sync_type syncInSync;
   logic [15:0] pixelInSync;
   logic pixclkInSync;
   logic captureClkSync;
   logic strapSync;
   logic featPinSync;
   logic powerDownNSync;

   assign pinRaw = {external_sync_select, external_video_select, external_pixclk_select,
                    syncPinIn, pixel_lines_in, pixel_clock_pin_in, capture_pixel_clock_in,
                    clock_bypass_strap, feature_enable_n_in, dac_power_down_n};

   fcp_sync2 #(
      .WIDTH(27)
   ) u_pin_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .asyncIn(pinRaw),
      .syncOut(pinSync)
   );

   // Unpack the synchronised pins
   assign selSync = pinSync[26:24];
   assign syncInSync = pinSync[23:21];
   assign pixelInSync = pinSync[20:5];
   assign pixclkInSync = pinSync[4];
   assign captureClkSync = pinSync[3];
   assign strapSync = pinSync[2];
   assign featPinSync = pinSync[1];
   assign powerDownNSync = pinSync[0];

   // ***************************************************************
   // Register file
   // ***************************************************************
   logic [7:0] seqExtCtrlB_reg;
   logic [7:0] seqExtCtrlD_reg;
   logic [7:0] pinMode_reg;
   logic [7:0] outputValue_reg;
   logic [15:0] captured_reg;
   logic strap_reg;
   logic strapDone_reg;
   logic [1:0] strapCount_reg;
   logic [1:0] strapCount_next;

   function automatic logic [7:0] fcp_merge(input logic [7:0] oldValue,
                                            input logic [7:0] newValue,
                                            input logic laneOn);
      fcp_merge = laneOn ? newValue : oldValue;
   endfunction : fcp_merge

   // Bus decode
   logic busRequest;
   logic writeStrobe;
   logic hitCtrlB;
   logic hitCtrlD;
   logic hitPinMode;
   logic hitOutputValue;
   logic hitStatus;
   logic hitCapture;
   logic [31:0] readData;
   logic [31:0] statusWord;

   assign busRequest = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign writeStrobe = busRequest & wb_we_i;
   assign hitCtrlB = (wb_adr_i == fcp_pkg::SEQ_EXT_CTRL_B_OFFSET);
   assign hitCtrlD = (wb_adr_i == fcp_pkg::SEQ_EXT_CTRL_D_OFFSET);
   assign hitPinMode = (wb_adr_i == fcp_pkg::PIN_MODE_OFFSET);
   assign hitOutputValue = (wb_adr_i == fcp_pkg::OUTPUT_VALUE_OFFSET);
   assign hitStatus = (wb_adr_i == fcp_pkg::PIN_STATUS_OFFSET);
   assign hitCapture = (wb_adr_i == fcp_pkg::CAPTURE_DATA_OFFSET);

   // Status shows the live select levels, the caught strap and the pin states
   assign statusWord = {24'h0000_00, 1'b0, strapDone_reg, strap_reg, powerDownNSync,
                        selSync, featPinSync};

   // Read selection; unmapped addresses read as zero
   assign readData = hitCtrlB ? {24'h0000_00, seqExtCtrlB_reg} :
                     hitCtrlD ? {24'h0000_00, seqExtCtrlD_reg} :
                     hitPinMode ? {24'h0000_00, pinMode_reg} :
                     hitOutputValue ? {24'h0000_00, outputValue_reg} :
                     hitStatus ? statusWord :
                     hitCapture ? {16'h0000, captured_reg} : 32'h0000_0000;

   // Every request is answered one cycle later, mapped or not
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= busRequest;
         wb_dat_o <= (busRequest & ~wb_we_i) ? readData : 32'h0000_0000;
      end
   end

   // Control registers take byte lane 0 only; upper lanes hold nothing
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         seqExtCtrlB_reg <= fcp_pkg::SEQ_EXT_CTRL_B_RESET;
         seqExtCtrlD_reg <= fcp_pkg::SEQ_EXT_CTRL_D_RESET;
         pinMode_reg <= fcp_pkg::PIN_MODE_RESET;
         outputValue_reg <= fcp_pkg::OUTPUT_VALUE_RESET;
      end else if (writeStrobe) begin
         if (hitCtrlB) seqExtCtrlB_reg <= fcp_merge(seqExtCtrlB_reg, wb_dat_i[7:0], wb_sel_i[0]);
         if (hitCtrlD) seqExtCtrlD_reg <= fcp_merge(seqExtCtrlD_reg, wb_dat_i[7:0], wb_sel_i[0]);
         if (hitPinMode) pinMode_reg <= fcp_merge(pinMode_reg, wb_dat_i[7:0], wb_sel_i[0]);
         if (hitOutputValue) begin
            outputValue_reg <= fcp_merge(outputValue_reg, wb_dat_i[7:0], wb_sel_i[0]);
         end
      end
   end

   // ***************************************************************
   // Power-on strap capture
   // ***************************************************************
   // The strap is caught once, after the synchroniser has filled, so a
   // level still settling at reset release is never taken.
   assign strapCount_next = strapDone_reg ? strapCount_reg : strapCount_reg + 2'h1;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         strapCount_reg <= 2'h0;
         strapDone_reg <= 1'b0;
         strap_reg <= 1'b1;
      end else begin
         strapCount_reg <= strapCount_next;
         if (!strapDone_reg && strapCount_reg == fcp_pkg::STRAP_SETTLE_COUNT) begin
            strapDone_reg <= 1'b1;
            strap_reg <= strapSync;
         end
      end
   end

   // ***************************************************************
   // Mode decode
   // ***************************************************************
   logic featureOn;
   logic bypassOn;
   logic generalOutMode;
   logic featureMode;
   logic captureOn;

   assign featureOn = seqExtCtrlD_reg[fcp_pkg::FEATURE_ENABLE_BIT];
   assign bypassOn = strapDone_reg & ~strap_reg;
   assign generalOutMode = pinMode_reg[fcp_pkg::GENERAL_OUTPUT_MODE_BIT];
   assign featureMode = (pinMode_reg[1:0] == fcp_pkg::PIN_MODE_FEATURE);
   assign captureOn = seqExtCtrlB_reg[fcp_pkg::CAPTURE_ENABLE_BIT] & ~selSync.externalVideo;

   // ***************************************************************
   // Sync, blank, pixel and pixel clock pin drivers
   // ***************************************************************
   // Output enables only follow the select pins while the connector is
   // enabled; an input pin keeps its driver off so it never fights.
   logic syncDrive;
   logic videoDrive;
   logic pixclkDrive;

   assign syncDrive = selSync.externalSync & featureOn;
   assign videoDrive = selSync.externalVideo & featureOn;
   assign pixclkDrive = selSync.externalPixclk & featureOn;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         syncPinOut <= '0;
         syncPinOe <= '0;
         pixel_lines_out <= 16'h0000;
         pixel_lines_oe <= 16'h0000;
         pixel_clock_pin_out <= 1'b0;
         pixel_clock_pin_oe <= 1'b0;
      end else begin
         syncPinOut <= syncDrive ? intSync : '0;
         syncPinOe <= {3{syncDrive}};
         pixel_lines_out <= videoDrive ? intPixel : 16'h0000;
         pixel_lines_oe <= {16{videoDrive}};
         pixel_clock_pin_out <= pixclkDrive & intPixelClock;
         pixel_clock_pin_oe <= pixclkDrive;
      end
   end

   // Incoming syncs and the test pixel clock reach the back end only as inputs
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         extSync <= 3'b001;
         testPixelClock <= 1'b0;
      end else begin
         extSync <= selSync.externalSync ? 3'b001 : syncInSync;
         testPixelClock <= ~selSync.externalPixclk & pixclkInSync;
      end
   end

   // ***************************************************************
   // Video and analog output gating
   // ***************************************************************
   // A low blank from the connector only counts while blank is an input
   logic blankKill;
   logic powerDownActive;

   assign blankKill = ~selSync.externalSync & ~syncInSync.blankN;
   assign powerDownActive = ~bypassOn & ~powerDownNSync;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         videoOutputOn <= 1'b0;
         dacAnalogOn <= 1'b0;
         dotClockBypass <= 1'b0;
      end else begin
         videoOutputOn <= ~blankKill & ~powerDownActive;
         dacAnalogOn <= ~powerDownActive;
         dotClockBypass <= bypassOn & powerDownNSync;
      end
   end

   // ***************************************************************
   // Pixel capture on the capture clock
   // ***************************************************************
   // The capture clock is oversampled, so it must run well below a
   // quarter of the system clock; faster capture needs a real clock domain.
   logic captureClkLast_reg;
   logic captureEdge;

   assign captureEdge = captureClkSync & ~captureClkLast_reg;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         captureClkLast_reg <= 1'b0;
         captured_reg <= 16'h0000;
         capturedValid <= 1'b0;
      end else begin
         captureClkLast_reg <= captureClkSync;
         capturedValid <= captureEdge & captureOn & featureOn;
         if (captureEdge && captureOn && featureOn) begin
            captured_reg <= pixelInSync;
         end
      end
   end

   assign capturedPixel = captured_reg;

   // ***************************************************************
   // Shared feature enable and general output pins
   // ***************************************************************
   // With the bypass strap the feature pin turns into a clock input, so
   // its driver stays off regardless of the pin mode.
   logic featurePinValue;
   logic strobeFire;

   assign featurePinValue = generalOutMode ? outputValue_reg[0] :
                            ~(featureOn & featureMode);
   assign strobeFire = writeStrobe & hitOutputValue;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         feature_enable_n_out <= 1'b1;
         feature_enable_n_oe <= 1'b0;
         memClockBypassOn <= 1'b0;
         memClockBypass <= 1'b0;
      end else begin
         feature_enable_n_out <= bypassOn ? 1'b1 : featurePinValue;
         feature_enable_n_oe <= strapDone_reg & ~bypassOn;
         memClockBypassOn <= bypassOn;
         memClockBypass <= bypassOn & featPinSync;
      end
   end

   // Pin 1 carries output bit 1, or a one-cycle strobe per value write
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         general_output_pin1 <= 1'b0;
      end else if (generalOutMode) begin
         general_output_pin1 <= outputValue_reg[1];
      end else begin
         general_output_pin1 <= strobeFire;
      end
   end

endmodule : fcp_pin_control

/* File: verification/fcp_pin_control_chk.sv */
// Checker of bus answer, pin direction and general output timing
module fcp_pin_control_chk (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Wishbone slave side
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   // Selects and connector pins
   input wire logic external_sync_select,
   input wire logic external_video_select,
   input wire logic external_pixclk_select,
   input wire fcp_pkg::fcp_sync_type syncPinIn,
   input wire fcp_pkg::fcp_sync_type syncPinOe,
   input wire logic [15:0] pixel_lines_oe,
   input wire logic pixel_clock_pin_oe,
   input wire logic general_output_pin1,
   input wire logic videoOutputOn
);
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************************************
   // Shadow of the output port control bits
   // ***************************************************************
   logic takeWrite, takeOv, takeMode;
   logic takeOv_reg, modeBit_reg, ovBit_reg;
   assign takeWrite = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0];
   assign takeOv = takeWrite && wb_adr_i == fcp_pkg::OUTPUT_VALUE_OFFSET;
   assign takeMode = takeWrite && wb_adr_i == fcp_pkg::PIN_MODE_OFFSET;

   // Shadow updates at the taking edge, the same edge the register stores
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         takeOv_reg <= 1'b0;
         modeBit_reg <= 1'b0;
         ovBit_reg <= 1'b0;
      end else begin
         takeOv_reg <= takeOv;
         modeBit_reg <= takeMode ? wb_dat_i[1] : modeBit_reg;
         ovBit_reg <= takeOv ? wb_dat_i[1] : ovBit_reg;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack held longer than one cycle");
   req_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered in one cycle");
   sync_dir_a: assert property ((!external_sync_select)[*4] |-> syncPinOe == 3'b000)
      else $error("sync pins driven while selected as inputs");
   pix_dir_a: assert property ((!external_video_select)[*4] |-> pixel_lines_oe == 16'h0000)
      else $error("pixel lines driven while selected as inputs");
   clk_dir_a: assert property ((!external_pixclk_select)[*4] |-> !pixel_clock_pin_oe)
      else $error("pixel clock pin driven while selected as input");
   blank_video_a: assert property (
      (!external_sync_select && !syncPinIn.blankN)[*4] |-> !videoOutputOn)
      else $error("video stays on while external blank is low");
   strobe_pulse_a: assert property (
      wb_ack_o && takeOv_reg && !modeBit_reg |-> general_output_pin1 ##1 !general_output_pin1)
      else $error("write strobe is not a single pulse at the ack");
   gop_level_a: assert property (
      (modeBit_reg && !takeOv_reg)[*2] |-> general_output_pin1 == ovBit_reg)
      else $error("general output pin does not follow output value bit 1");
endmodule : fcp_pin_control_chk

bind fcp_pin_control fcp_pin_control_chk i_fcp_pin_control_chk (.*);

/* File: verification/fcp_far_end.sv */
// Model of the external video device on the feature connector
module fcp_far_end (
   // Clock
   input wire logic clk_sys,
   // Bench controls
   input wire fcp_pkg::fcp_select_type sel,
   input wire fcp_pkg::fcp_sync_type syncVal,
   input wire logic [15:0] pixVal,
   input wire logic featVal,
   input wire logic capRun,
   // Device pin drivers
   input wire fcp_pkg::fcp_sync_type syncOut,
   input wire fcp_pkg::fcp_sync_type syncOe,
   input wire logic [15:0] pixOut,
   input wire logic [15:0] pixOe,
   input wire logic clkOut,
   input wire logic clkOe,
   input wire logic featOut,
   input wire logic featOe,
   // Resolved pin levels
   output fcp_pkg::fcp_sync_type syncLine,
   output logic [15:0] pixLine,
   output logic clkLine,
   output logic capClk,
   output logic featLine
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_reg = 8'h00;

   // Free counter: toggle pattern for released lines, slow clocks for test
   always_ff @(posedge clk_sys) begin
      cnt_reg <= cnt_reg + 8'h01;
   end

   // Far side drives only while its select is low; a released line toggles
   // so that stale data can never pass for a driven value
   assign syncLine = (syncOe & syncOut) | (~syncOe & (sel.externalSync ? {3{cnt_reg[0]}} : syncVal));
   assign pixLine = (pixOe & pixOut) | (~pixOe & (sel.externalVideo ? {16{cnt_reg[0]}} : pixVal));
   assign clkLine = clkOe ? clkOut : (sel.externalPixclk ? cnt_reg[0] : cnt_reg[3]);
   // Capture clock high and low 8 cycles each; pixel data held by the bench
   assign capClk = capRun & cnt_reg[3];
   assign featLine = featOe ? featOut : featVal;
endmodule : fcp_far_end

/* File: verification/tb.sv */
// Self-checking bench for the feature connector pin control
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************************************
   // Design ports and bench state
   // ***************************************************************
   logic clk_sys = 1'b0;
   logic reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, intPixelClock;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rng, rdData;
   logic clock_bypass_strap, dac_power_down_n, featVal, capRun;
   logic external_sync_select, external_video_select, external_pixclk_select;
   fcp_pkg::fcp_select_type selPins;
   fcp_pkg::fcp_sync_type intSync, syncPinIn, syncPinOut, syncPinOe, extSync, syncVal;
   logic [15:0] intPixel, pixel_lines_in, pixel_lines_out, pixel_lines_oe, capturedPixel, pixVal;
   logic pixel_clock_pin_in, pixel_clock_pin_out, pixel_clock_pin_oe, capture_pixel_clock_in;
   logic feature_enable_n_in, feature_enable_n_out, feature_enable_n_oe, general_output_pin1;
   logic videoOutputOn, dacAnalogOn, capturedValid, testPixelClock;
   logic memClockBypassOn, memClockBypass, dotClockBypass;
   logic [7:0] mdl [0:3];
   int badCount = 0;
   int nTests = 0;

   assign {external_sync_select, external_video_select, external_pixclk_select} = selPins;
   // Free running 100 MHz clock
   always #5 clk_sys = ~clk_sys;

   fcp_pin_control i_fcp_pin_control (.*);
   fcp_far_end i_fcp_far_end (.clk_sys(clk_sys), .sel(selPins), .syncVal(syncVal),
      .pixVal(pixVal), .featVal(featVal), .capRun(capRun), .syncOut(syncPinOut),
      .syncOe(syncPinOe), .pixOut(pixel_lines_out), .pixOe(pixel_lines_oe),
      .clkOut(pixel_clock_pin_out), .clkOe(pixel_clock_pin_oe), .featOut(feature_enable_n_out),
      .featOe(feature_enable_n_oe), .syncLine(syncPinIn), .pixLine(pixel_lines_in),
      .clkLine(pixel_clock_pin_in), .capClk(capture_pixel_clock_in),
      .featLine(feature_enable_n_in));

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function automatic logic [31:0] lfsrNext(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsrNext

   task automatic step();
      rng = lfsrNext(rng);
   endtask : step

   task automatic settle();
      repeat (8) @(posedge clk_sys);
   endtask : settle

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      nTests++;
      if (g !== e) begin
         badCount++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Classic single cycle; the model register follows a taken write with lane 0
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge clk_sys);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do begin
         @(posedge clk_sys);
      end while (wb_ack_o !== 1'b1);
      rdData = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      if (we && s[0] && a < 8'h10) mdl[a[3:2]] = d[7:0];
   endtask : bus

   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, rng, 4'hf);
      chk("readData", a < 8'h10 ? {24'h0, mdl[a[3:2]]} : 32'h0, rdData);
   endtask : rd

   task automatic results();
      if (badCount == 0 && nTests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results

   // Watchdog: the whole sequence needs far fewer cycles than this
   initial begin
      repeat (20000) @(posedge clk_sys);
      badCount++;
      results();
   end

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      rng = 32'hf2fe_590c;
      reset_n = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0000_0000;
      selPins = 3'b000;
      syncVal = 3'b111;
      {clock_bypass_strap, dac_power_down_n, featVal, capRun} = 4'b1110;
      intSync = rng[2:0];
      intPixel = rng[31:16];
      intPixelClock = rng[3];
      pixVal = rng[15:0];
      mdl = '{fcp_pkg::SEQ_EXT_CTRL_B_RESET, fcp_pkg::SEQ_EXT_CTRL_D_RESET,
              fcp_pkg::PIN_MODE_RESET, fcp_pkg::OUTPUT_VALUE_RESET};
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      // Reset values, lane 0 gating and an unmapped place
      for (int a = 0; a < 5; a++) begin
         logic [7:0] ad;
         ad = (a == 4) ? 8'h20 : 8'(a * 4);
         step();
         rd(ad);
         bus(1'b1, ad, rng, 4'he);
         rd(ad);
         bus(1'b1, ad, rng, 4'h1);
         rd(ad);
      end
      // Directions follow the selects once the connector is enabled
      bus(1'b1, fcp_pkg::PIN_MODE_OFFSET, 32'h0, 4'h1);
      bus(1'b1, fcp_pkg::SEQ_EXT_CTRL_D_OFFSET, 32'h1, 4'h1);
      selPins <= 3'b111;
      settle();
      chk("syncOe", 32'h7, {29'h0, syncPinOe});
      chk("pixOe", 32'hffff, {16'h0, pixel_lines_oe});
      chk("clkOe", 32'h1, {31'h0, pixel_clock_pin_oe});
      chk("pixOut", {16'h0, intPixel}, {16'h0, pixel_lines_out});
      chk("syncOut", {29'h0, intSync}, {29'h0, syncPinOut});
      chk("clkOut", {31'h0, intPixelClock}, {31'h0, pixel_clock_pin_out});
      chk("testClk", 32'h0, {31'h0, testPixelClock});
      selPins <= 3'b000;
      syncVal <= rng[2:0] | 3'b001;
      settle();
      chk("syncOff", 32'h0, {29'h0, syncPinOe});
      chk("pixOff", 32'h0, {16'h0, pixel_lines_oe});
      chk("clkOff", 32'h0, {31'h0, pixel_clock_pin_oe});
      chk("extSync", {29'h0, rng[2:0] | 3'b001}, {29'h0, extSync});
      chk("videoOn", 32'h1, {31'h0, videoOutputOn});
      syncVal <= syncVal & 3'b110;
      settle();
      chk("videoOff", 32'h0, {31'h0, videoOutputOn});
      // Feature pin in every pin mode, general output 1 in pin modes 2 and 3
      step();
      bus(1'b1, fcp_pkg::OUTPUT_VALUE_OFFSET, rng, 4'h1);
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, fcp_pkg::PIN_MODE_OFFSET, 32'(m), 4'h1);
         settle();
         chk("featN", m > 1 ? {31'h0, rng[0]} : {31'h0, m != 0}, {31'h0, feature_enable_n_out});
         chk("featOe", 32'h1, {31'h0, feature_enable_n_oe});
         if (m > 1) chk("gop1", {31'h0, rng[1]}, {31'h0, general_output_pin1});
      end
      bus(1'b1, fcp_pkg::PIN_MODE_OFFSET, 32'h0, 4'h1);
      bus(1'b1, fcp_pkg::SEQ_EXT_CTRL_D_OFFSET, 32'h0, 4'h1);
      settle();
      chk("featOffN", 32'h1, {31'h0, feature_enable_n_out});
      bus(1'b1, fcp_pkg::SEQ_EXT_CTRL_D_OFFSET, 32'h1, 4'h1);
      // Capture with the enable bit set, then with it clear
      for (int k = 0; k < 2; k++) begin
         int n;
         step();
         bus(1'b1, fcp_pkg::SEQ_EXT_CTRL_B_OFFSET, k ? 32'h0 : 32'h2, 4'h1);
         pixVal <= rng[15:0];
         capRun <= 1'b1;
         n = 0;
         while (capturedValid !== 1'b1 && n < 40) begin
            @(posedge clk_sys);
            n++;
         end
         chk("capValid", k ? 32'h0 : 32'h1, {31'h0, capturedValid});
         if (k == 0) chk("capData", {16'h0, rng[15:0]}, {16'h0, capturedPixel});
         capRun <= 1'b0;
      end
      // Power-down pin turns the analog outputs off
      for (int p = 0; p < 2; p++) begin
         dac_power_down_n <= p[0];
         settle();
         chk("dacOn", 32'(p), {31'h0, dacAnalogOn});
      end
      // Bypass strap caught low: the feature pin and the power-down pin become clock inputs
      reset_n <= 1'b0;
      clock_bypass_strap <= 1'b0;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      settle();
      settle();
      chk("bypassOn", 32'h1, {31'h0, memClockBypassOn});
      chk("bypassOe", 32'h0, {31'h0, feature_enable_n_oe});
      for (int p = 0; p < 2; p++) begin
         featVal <= p[0];
         dac_power_down_n <= p[0];
         settle();
         chk("memClk", 32'(p), {31'h0, memClockBypass});
         chk("dotClk", 32'(p), {31'h0, dotClockBypass});
      end
      results();
   end
endmodule : tb
